/* src/mcu_decode_pkg.sv */
package mcu_decode_pkg;
	localparam int IW          = 14;
	localparam int Q_PER_CYCLE = 4;
	// Opcode classes in bits 13:12
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT  = 2'h1;
	localparam logic [1:0] CLS_CTRL = 2'h2;
	localparam logic [1:0] CLS_EXT  = 2'h3;
	// Group codes reported to software
	localparam logic [1:0] GRP_BYTE = 2'h0;
	localparam logic [1:0] GRP_BIT  = 2'h1;
	localparam logic [1:0] GRP_LIT  = 2'h2;
	// Operation fields in bits 11:8
	localparam logic [3:0] OP_MOVE   = 4'h0;
	localparam logic [3:0] OP_AND    = 4'h5;
	localparam logic [3:0] OP_ADD    = 4'h7;
	localparam logic [3:0] OP_DECSZ  = 4'hb;
	localparam logic [3:0] OP_INCSZ  = 4'hf;
	localparam logic [3:0] OP_ADDC   = 4'hd;
	localparam logic [3:0] OP_ASR    = 4'h7;
	localparam logic [3:0] OP_LSL    = 4'h5;
	localparam logic [3:0] OP_LSR    = 4'h6;
	localparam logic [3:0] OP_SUBB   = 4'hb;
	localparam logic [3:0] OP_EXITL  = 4'h4;
	localparam logic [2:0] OP_RELJ   = 3'h1;
	localparam logic [1:0] BOP_CLR   = 2'h0;
	localparam logic [1:0] BOP_SET   = 2'h1;
	localparam logic [1:0] BOP_SKC   = 2'h2;
	localparam logic [1:0] BOP_SKS   = 2'h3;
	// Whole-word control encodings, indirect-move prefix bits 13:4, indirect port address bits 6:1
	localparam logic [13:0] OPW_RETURN = 14'h0008;
	localparam logic [13:0] OPW_IEXIT  = 14'h0009;
	localparam logic [13:0] OPW_CALLACC = 14'h000a;
	localparam logic [13:0] OPW_JACC   = 14'h000b;
	localparam logic [9:0]  OPW_INDIR  = 10'h001;
	localparam logic [5:0]  IPORT_HI   = 6'h00;
	// Register offsets
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_WREG    = 8'h08;
	localparam logic [7:0] ADDR_INFO    = 8'h0c;
	localparam logic [7:0] ADDR_RETIRED = 8'h10;
	// Status fields
	localparam int ST_C  = 0;
	localparam int ST_DIG   = 1;
	localparam int ST_Z     = 2;
	localparam int ST_PWRDN = 3;
	localparam int ST_TMOUT = 4;
	localparam logic [4:0] STATUS_RST = 5'h18;
	localparam logic [1:0] CTRL_RST   = 2'h0;
	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_RUN   = 2'b01,
		S_EXTRA = 2'b10
	} state_t;
endpackage

/* src/mcu_instruction_decode_timing.sv */
// Function
// - Each instruction arrives as one 14-bit word holding the opcode and all operands.
// - Every opcode is sorted into byte-oriented, bit-oriented or literal/control groups.
// - An instruction cycle is 4 clocks and ordinary instructions take one cycle.
// - Direct call and call through the accumulator take two cycles.
// - Return, return with literal and interrupt exit take two cycles.
// - Jumps, and skip operations that skip, take two cycles.
// - Touching the indirect port while its pointer addresses program memory adds one cycle.
// - A file-register instruction always reads the register before any write back.
// - Destination bit 0 sends the result to the working register, 1 back to the file register.
// - The file address is a 7-bit field covering 0x00 to 0x7F.
// - The bit operand picks one of the 8 bits of the addressed register.
// - Don't-care opcode bits are ignored, whatever value they hold.
// - Indirect instructions carry a pointer index and a pre/post increment/decrement mode.
// - Add, add with carry and AND decode to their codes and update carry, digit carry and zero as listed.
// - Arithmetic right and logical left shifts decode to their codes and update carry and zero.
//
// The implementer's own choices: the APB slave port and the register offsets.
module mcu_instruction_decode_timing #(
	parameter int Q_PER_CYCLE = mcu_decode_pkg::Q_PER_CYCLE
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [13:0] instr_word,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	output logic      [6:0]  file_addr,
	output logic             file_rd_en,
	input  wire logic [7:0]  file_rd_data,
	output logic             file_wr_en,
	output logic      [7:0]  file_wr_data,
	output logic             ptr_update,
	output logic             ptr_sel,
	output logic      [1:0]  ptr_mode,
	output logic             cycle_end,
	output logic             instr_done
);
	localparam logic [1:0] Q_LAST = 2'(Q_PER_CYCLE - 1);
	localparam logic [1:0] Q_READ = 2'h0;
	localparam logic [1:0] Q_EXEC = 2'h2;

	mcu_decode_pkg::state_t state_reg;
	logic [13:0] ir_reg;
	logic [1:0]  q_reg;
	logic [1:0]  extra_reg;
	logic [7:0]  w_reg;
	logic [4:0]  status_reg;
	logic [1:0]  ctrl_reg;
	logic [1:0]  last_grp_reg;
	logic [1:0]  last_cyc_reg;
	logic [15:0] retired_reg;

	logic [1:0] cls, bop, grp, extra_next;
	logic [3:0] op;
	logic [2:0] bitn;
	logic       dst, is_byte, is_bit, is_file, fixed_two, is_indir, ind_prog, wr_file, wr_w;
	logic [7:0] res;
	logic [8:0] sum;
	logic [4:0] nib;
	logic       res_c, res_dig, upd_c, upd_dig, upd_z, skip;
	logic       commit, wr_ok, rd_ok, ok;

	// Decode; fields below bit 8 that an opcode does not use are never looked at
	always_comb begin
		cls  = ir_reg[13:12];
		op   = ir_reg[11:8];
		bop  = ir_reg[11:10];
		dst  = ir_reg[7];
		bitn = ir_reg[9:7];
		is_bit  = (cls == mcu_decode_pkg::CLS_BIT);
		is_byte = ((cls == mcu_decode_pkg::CLS_BYTE) && ((op != mcu_decode_pkg::OP_MOVE) || dst)) ||
			((cls == mcu_decode_pkg::CLS_EXT) && ((op == mcu_decode_pkg::OP_ADDC) ||
			(op == mcu_decode_pkg::OP_ASR) || (op == mcu_decode_pkg::OP_LSL) ||
			(op == mcu_decode_pkg::OP_LSR) || (op == mcu_decode_pkg::OP_SUBB)));
		is_file = is_byte || is_bit;
		if (is_byte) begin
			grp = mcu_decode_pkg::GRP_BYTE;
		end else if (is_bit) begin
			grp = mcu_decode_pkg::GRP_BIT;
		end else begin
			grp = mcu_decode_pkg::GRP_LIT;
		end
		fixed_two = (cls == mcu_decode_pkg::CLS_CTRL) ||
			(ir_reg == mcu_decode_pkg::OPW_CALLACC) ||
			(ir_reg == mcu_decode_pkg::OPW_RETURN) || (ir_reg == mcu_decode_pkg::OPW_IEXIT) ||
			((cls == mcu_decode_pkg::CLS_EXT) && (op == mcu_decode_pkg::OP_EXITL)) ||
			(ir_reg == mcu_decode_pkg::OPW_JACC) ||
			((cls == mcu_decode_pkg::CLS_EXT) && (op[3:1] == mcu_decode_pkg::OP_RELJ));
		is_indir = (ir_reg[13:4] == mcu_decode_pkg::OPW_INDIR);
		if (is_indir) begin
			ind_prog = ctrl_reg[ir_reg[2]];
		end else begin
			ind_prog = is_file && (ir_reg[6:1] == mcu_decode_pkg::IPORT_HI) && ctrl_reg[ir_reg[0]];
		end
	end

	// Result and flags, formed from the value read in the previous quarter
	always_comb begin
		res    = file_rd_data;
		sum    = 9'h000;
		nib    = 5'h00;
		res_c  = 1'b0;
		res_dig = 1'b0;
		upd_c  = 1'b0;
		upd_dig = 1'b0;
		upd_z  = 1'b0;
		skip   = 1'b0;
		wr_file = is_byte && dst;
		wr_w    = is_byte && !dst;
		if (is_bit) begin
			wr_file = (bop == mcu_decode_pkg::BOP_CLR) || (bop == mcu_decode_pkg::BOP_SET);
			case (bop)
				mcu_decode_pkg::BOP_CLR: res[bitn] = 1'b0;
				mcu_decode_pkg::BOP_SET: res[bitn] = 1'b1;
				mcu_decode_pkg::BOP_SKC: skip = !file_rd_data[bitn];
				default:                 skip = file_rd_data[bitn];
			endcase
		end else if (is_byte && (cls == mcu_decode_pkg::CLS_BYTE)) begin
			case (op)
				mcu_decode_pkg::OP_MOVE: res = w_reg;
				mcu_decode_pkg::OP_ADD: begin
					sum    = {1'b0, file_rd_data} + {1'b0, w_reg};
					nib    = {1'b0, file_rd_data[3:0]} + {1'b0, w_reg[3:0]};
					res    = sum[7:0];
					res_c  = sum[8];
					res_dig = nib[4];
					upd_c  = 1'b1;
					upd_dig = 1'b1;
					upd_z  = 1'b1;
				end
				mcu_decode_pkg::OP_AND: begin
					res   = file_rd_data & w_reg;
					upd_z = 1'b1;
				end
				mcu_decode_pkg::OP_DECSZ: begin
					res  = file_rd_data - 8'h01;
					skip = (res == 8'h00);
				end
				mcu_decode_pkg::OP_INCSZ: begin
					res  = file_rd_data + 8'h01;
					skip = (res == 8'h00);
				end
				default: res = file_rd_data;
			endcase
		end else if (is_byte) begin
			case (op)
				mcu_decode_pkg::OP_ADDC: begin
					sum    = {1'b0, file_rd_data} + {1'b0, w_reg} + {8'h00, status_reg[mcu_decode_pkg::ST_C]};
					nib    = {1'b0, file_rd_data[3:0]} + {1'b0, w_reg[3:0]} + {4'h0, status_reg[mcu_decode_pkg::ST_C]};
					res    = sum[7:0];
					res_c  = sum[8];
					res_dig = nib[4];
					upd_c  = 1'b1;
					upd_dig = 1'b1;
					upd_z  = 1'b1;
				end
				mcu_decode_pkg::OP_ASR: begin
					res   = {file_rd_data[7], file_rd_data[7:1]};
					res_c = file_rd_data[0];
					upd_c = 1'b1;
					upd_z = 1'b1;
				end
				mcu_decode_pkg::OP_LSL: begin
					res   = {file_rd_data[6:0], 1'b0};
					res_c = file_rd_data[7];
					upd_c = 1'b1;
					upd_z = 1'b1;
				end
				default: res = file_rd_data;
			endcase
		end
		extra_next = {1'b0, fixed_two || skip} + {1'b0, ind_prog};
	end

	assign commit      = (state_reg == mcu_decode_pkg::S_RUN) && (q_reg == Q_EXEC);
	assign instr_ready = (state_reg == mcu_decode_pkg::S_IDLE);
	assign ok    = (paddr == mcu_decode_pkg::ADDR_CTRL) || (paddr == mcu_decode_pkg::ADDR_STATUS) ||
		(paddr == mcu_decode_pkg::ADDR_WREG) || (paddr == mcu_decode_pkg::ADDR_INFO) ||
		(paddr == mcu_decode_pkg::ADDR_RETIRED);
	assign wr_ok   = psel && penable && pwrite && ok;
	assign rd_ok   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !ok;

	// Sequencer: one quarter per clock, extra whole cycles after the base one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= mcu_decode_pkg::S_IDLE;
			q_reg     <= 2'h0;
			extra_reg <= 2'h0;
			ir_reg    <= 14'h0000;
		end else begin
			case (state_reg)
				mcu_decode_pkg::S_IDLE: begin
					if (instr_valid) begin
						ir_reg    <= instr_word;
						state_reg <= mcu_decode_pkg::S_RUN;
						q_reg     <= 2'h0;
					end
				end
				mcu_decode_pkg::S_RUN: begin
					q_reg <= q_reg + 2'h1;
					if (commit) begin
						extra_reg <= extra_next;
					end
					if (q_reg == Q_LAST) begin
						q_reg     <= 2'h0;
						state_reg <= (extra_reg != 2'h0) ? mcu_decode_pkg::S_EXTRA : mcu_decode_pkg::S_IDLE;
					end
				end
				mcu_decode_pkg::S_EXTRA: begin
					q_reg <= q_reg + 2'h1;
					if (q_reg == Q_LAST) begin
						q_reg     <= 2'h0;
						extra_reg <= extra_reg - 2'h1;
						if (extra_reg == 2'h1) begin
							state_reg <= mcu_decode_pkg::S_IDLE;
						end
					end
				end
				default: state_reg <= mcu_decode_pkg::S_IDLE;
			endcase
		end
	end

	// File port: read in the second quarter, write back in the fourth
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			file_addr    <= 7'h00;
			file_rd_en   <= 1'b0;
			file_wr_en   <= 1'b0;
			file_wr_data <= 8'h00;
		end else begin
			if (instr_ready && instr_valid) begin
				file_addr <= instr_word[6:0];
			end
			file_rd_en   <= (state_reg == mcu_decode_pkg::S_RUN) && (q_reg == Q_READ) && is_file;
			file_wr_en   <= commit && wr_file;
			if (commit && wr_file) begin
				file_wr_data <= res;
			end
		end
	end

	// Pointer adjust request for indirect moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_update <= 1'b0;
			ptr_sel    <= 1'b0;
			ptr_mode   <= 2'h0;
		end else begin
			ptr_update <= commit && is_indir;
			if (commit && is_indir) begin
				ptr_sel  <= ir_reg[2];
				ptr_mode <= ir_reg[1:0];
			end
		end
	end

	// Cycle and completion strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_end    <= 1'b0;
			instr_done   <= 1'b0;
			last_grp_reg <= 2'h0;
			last_cyc_reg <= 2'h0;
			retired_reg  <= 16'h0000;
		end else begin
			cycle_end  <= (state_reg != mcu_decode_pkg::S_IDLE) && (q_reg == Q_LAST);
			instr_done <= (q_reg == Q_LAST) && (((state_reg == mcu_decode_pkg::S_RUN) && (extra_reg == 2'h0)) ||
				((state_reg == mcu_decode_pkg::S_EXTRA) && (extra_reg == 2'h1)));
			if (commit) begin
				last_grp_reg <= grp;
				last_cyc_reg <= extra_next + 2'h1;
				retired_reg  <= retired_reg + 16'h0001;
			end
		end
	end

	// Working register; an instruction result wins over a same-cycle bus write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			w_reg <= 8'h00;
		end else if (commit && wr_w) begin
			w_reg <= res;
		end else if (wr_ok && (paddr == mcu_decode_pkg::ADDR_WREG)) begin
			w_reg <= pwdata[7:0];
		end
	end

	// Status flags, each updated bit by bit so unaffected flags hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= mcu_decode_pkg::STATUS_RST;
		end else begin
			if (wr_ok && (paddr == mcu_decode_pkg::ADDR_STATUS)) begin
				status_reg <= pwdata[4:0];
			end
			if (commit && upd_c) begin
				status_reg[mcu_decode_pkg::ST_C] <= res_c;
			end
			if (commit && upd_dig) begin
				status_reg[mcu_decode_pkg::ST_DIG] <= res_dig;
			end
			if (commit && upd_z) begin
				status_reg[mcu_decode_pkg::ST_Z] <= (res == 8'h00);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= mcu_decode_pkg::CTRL_RST;
		end else if (wr_ok && (paddr == mcu_decode_pkg::ADDR_CTRL)) begin
			ctrl_reg <= pwdata[1:0];
		end
	end

	// Read data is captured in the setup phase so the access needs no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_ok) begin
			if (paddr == mcu_decode_pkg::ADDR_CTRL) begin
				prdata <= {30'h0, ctrl_reg};
			end else if (paddr == mcu_decode_pkg::ADDR_STATUS) begin
				prdata <= {27'h0, status_reg};
			end else if (paddr == mcu_decode_pkg::ADDR_WREG) begin
				prdata <= {24'h0, w_reg};
			end else if (paddr == mcu_decode_pkg::ADDR_INFO) begin
				prdata <= {27'h0, instr_ready, last_cyc_reg, last_grp_reg};
			end else if (paddr == mcu_decode_pkg::ADDR_RETIRED) begin
				prdata <= {16'h0, retired_reg};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

/* test/file_reg_model.sv */
module file_reg_model (
	input  wire logic       pclk,
	input  wire logic [6:0] file_addr,
	input  wire logic       file_rd_en,
	output logic      [7:0] file_rd_data,
	input  wire logic       file_wr_en,
	input  wire logic [7:0] file_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [128];
	initial begin
		file_rd_data = 8'h00;
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	always @(posedge pclk) begin
		if (file_rd_en)
			file_rd_data <= mem[file_addr];
		else
			file_rd_data <= ~file_rd_data; // Stale data flips so a late sample is caught
		if (file_wr_en)
			mem[file_addr] <= file_wr_data;
	end
endmodule

/* test/decode_checker.sv */
module decode_checker #(
	parameter int Q_PER_CYCLE = 4
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [13:0] instr_word,
	input wire logic        instr_valid,
	input wire logic        instr_ready,
	input wire logic [6:0]  file_addr,
	input wire logic        file_rd_en,
	input wire logic        file_wr_en,
	input wire logic        ptr_update,
	input wire logic        cycle_end,
	input wire logic        instr_done
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic acc = instr_valid & instr_ready;
	wire logic file_op = !instr_word[13] && (instr_word[13:7] != 7'h00);
	wire logic add_op = (instr_word[13:8] == {2'h0, mcu_decode_pkg::OP_ADD}) && (instr_word[6:1] != 6'h00);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_two_cycle;
		##5 (cycle_end && !instr_done) ##4 (cycle_end && instr_done);
	endsequence
	property p_read_first; acc && file_op |-> ##2 file_rd_en; endproperty
	a_read_first: assert property (p_read_first) else $error("file read missing");
	property p_busy; acc |=> !instr_ready [*4]; endproperty
	a_busy: assert property (p_busy) else $error("accepted while busy");
	property p_one_add; acc && add_op |-> ##5 (cycle_end && instr_done); endproperty
	a_one_add: assert property (p_one_add) else $error("add not one cycle");
	property p_rd_to_end; file_rd_en |-> ##3 cycle_end; endproperty
	a_rd_to_end: assert property (p_rd_to_end) else $error("read quarter misplaced");
	property p_wr_to_end; file_wr_en |=> cycle_end; endproperty
	a_wr_to_end: assert property (p_wr_to_end) else $error("write quarter misplaced");
	property p_ptr_to_end; ptr_update |=> cycle_end; endproperty
	a_ptr_to_end: assert property (p_ptr_to_end) else $error("pointer update misplaced");
	property p_done_end; instr_done |-> cycle_end; endproperty
	a_done_end: assert property (p_done_end) else $error("done off cycle boundary");
	property p_addr; acc |-> ##2 file_addr == $past(instr_word[6:0], 2); endproperty
	a_addr: assert property (p_addr) else $error("file address wrong");
	property p_return; acc && instr_word == mcu_decode_pkg::OPW_RETURN |-> s_two_cycle; endproperty
	a_return: assert property (p_return) else $error("return not two cycles");
	property p_call_acc; acc && instr_word == mcu_decode_pkg::OPW_CALLACC |-> s_two_cycle; endproperty
	a_call_acc: assert property (p_call_acc) else $error("call not two cycles");
endmodule
bind mcu_instruction_decode_timing decode_checker #(.Q_PER_CYCLE(Q_PER_CYCLE)) u_chk (.pclk(pclk),
	.presetn(presetn), .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready),
	.file_addr(file_addr), .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .ptr_update(ptr_update),
	.cycle_end(cycle_end), .instr_done(instr_done));

/* test/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, file_wr_data, file_rd_data;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] instr_word;
	logic        instr_valid, instr_ready, file_rd_en, file_wr_en, ptr_update, ptr_sel, cycle_end, instr_done, err;
	logic [6:0]  file_addr;
	logic [1:0]  ptr_mode;
	int          error_cnt = 0;
	int          check_count = 0;
	int          retired = 0;
	logic [13:0] tw [12] = '{14'h0008, 14'h0009, 14'h000a, 14'h000b, 14'h2000, 14'h2800, 14'h3200, 14'h3400,
		14'h1d31, 14'h1931, 14'h0bb2, 14'h0f2a};
	int          tc [12] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 1, 2, 1};
	logic [1:0]  tg [12] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
	mcu_instruction_decode_timing #(.Q_PER_CYCLE(4)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready),
		.file_addr(file_addr), .file_rd_en(file_rd_en), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
		.file_wr_data(file_wr_data), .ptr_update(ptr_update), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode),
		.cycle_end(cycle_end), .instr_done(instr_done));
	file_reg_model u_mem (.pclk(pclk), .file_addr(file_addr), .file_rd_en(file_rd_en),
		.file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic wrap_up();
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		check(name, exp, rd);
	endtask
	// Counts cycle boundaries, so the figure is in instruction cycles, not clocks
	task automatic run(input logic [13:0] w, input int cyc);
		int ends;
		ends = 0;
		@(posedge pclk);
		instr_word <= w;
		instr_valid <= 1'b1;
		@(posedge pclk);
		while (instr_ready !== 1'b1)
			@(posedge pclk);
		instr_valid <= 1'b0;
		do begin
			@(posedge pclk);
			if (cycle_end === 1'b1)
				ends++;
		end while (instr_done !== 1'b1);
		retired++;
		check("instruction cycles", cyc, ends);
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		error_cnt++;
		wrap_up();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, instr_valid} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		instr_word = 14'h0000;
		repeat (4) @(posedge pclk);
		u_mem.mem[7'h27] = 8'hcb;
		u_mem.mem[7'h28] = 8'h0f;
		u_mem.mem[7'h29] = 8'h81;
		u_mem.mem[7'h2a] = 8'h80;
		u_mem.mem[7'h31] = 8'h04;
		u_mem.mem[7'h32] = 8'h01;
		presetn <= 1'b1;
		rd_chk("status", mcu_decode_pkg::ADDR_STATUS, 32'h18);
		rd_chk("wreg", mcu_decode_pkg::ADDR_WREG, 32'h0);
		rd_chk("unmapped", 8'h20, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err});
		apb(mcu_decode_pkg::ADDR_WREG, 1'b1, 32'h35);
		run(14'h07a7, 1);
		check("file 27", 32'h0, u_mem.mem[7'h27]);
		rd_chk("status", mcu_decode_pkg::ADDR_STATUS, 32'h1f);
		run(14'h0528, 1);
		rd_chk("wreg", mcu_decode_pkg::ADDR_WREG, 32'h05);
		rd_chk("status", mcu_decode_pkg::ADDR_STATUS, 32'h1b);
		check("file 28", 32'h0f, u_mem.mem[7'h28]);
		run(14'h3d28, 1);
		rd_chk("wreg", mcu_decode_pkg::ADDR_WREG, 32'h15);
		rd_chk("status", mcu_decode_pkg::ADDR_STATUS, 32'h1a);
		run(14'h37a9, 1);
		check("file 29", 32'hc0, u_mem.mem[7'h29]);
		rd_chk("status", mcu_decode_pkg::ADDR_STATUS, 32'h1b);
		run(14'h35aa, 1);
		check("file 2a", 32'h0, u_mem.mem[7'h2a]);
		rd_chk("status", mcu_decode_pkg::ADDR_STATUS, 32'h1f);
		run(14'h16b0, 1);
		check("file 30", 32'h20, u_mem.mem[7'h30]);
		run(14'h12b0, 1);
		check("file 30", 32'h0, u_mem.mem[7'h30]);
		for (int i = 0; i < 12; i++) begin
			run(tw[i], tc[i]);
			apb(mcu_decode_pkg::ADDR_INFO, 1'b0, 32'h0);
			check("group", {30'h0, tg[i]}, {30'h0, rd[1:0]});
		end
		for (int i = 0; i < 8; i++) begin
			run(14'h0010 + 14'(i), 1);
			check("pointer index", 32'(i[2]), {31'h0, ptr_sel});
			check("pointer mode", 32'(i[1:0]), {30'h0, ptr_mode});
		end
		apb(mcu_decode_pkg::ADDR_CTRL, 1'b1, 32'h1);
		run(14'h0700, 2);
		run(14'h0701, 1);
		rd_chk("retired", mcu_decode_pkg::ADDR_RETIRED, 32'(retired));
		wrap_up();
	end
endmodule
